// >>> shared/sdadc_pkg.sv
// package: register map, field layout and types of the sigma-delta converter control block
package sdadc_pkg;
	// ---------------------------------------------
	// register offsets
	// ---------------------------------------------
	localparam logic [7:0] ADDR_RESULT_HIGH   = 8'h3a;
	localparam logic [7:0] ADDR_RESULT_MIDDLE = 8'h3b;
	localparam logic [7:0] ADDR_RESULT_LOW    = 8'h3c;
	localparam logic [7:0] ADDR_CTRL_ENABLE   = 8'h3d;
	localparam logic [7:0] ADDR_CTRL_GAIN     = 8'h3e;
	localparam logic [7:0] ADDR_CTRL_BIAS     = 8'h3f;
	localparam logic [7:0] ADDR_CTRL_INPUT    = 8'h40;
	localparam logic [7:0] ADDR_CTRL_REF      = 8'h41;
	localparam logic [7:0] ADDR_CTRL_SWITCH   = 8'h42;
	localparam logic [7:0] ADDR_PULLDOWN_A    = 8'h47;
	localparam logic [7:0] ADDR_PULLDOWN_B    = 8'h48;
	// ---------------------------------------------
	// reset values and masks
	// ---------------------------------------------
	localparam logic [7:0] RST_ZERO        = 8'h00;
	localparam logic [7:0] RST_CTRL_REF    = 8'h20;
	localparam logic [7:0] MASK_HIGH       = 8'h3f;
	localparam logic [7:0] MASK_ENABLE     = 8'h9e;
	localparam logic [7:0] MASK_GAIN       = 8'h27;
	localparam logic [7:0] MASK_BIAS       = 8'h7f;
	localparam logic [7:0] MASK_SWITCH     = 8'hfb;
	localparam logic [7:0] MASK_PULLDOWN_A = 8'hc0;
	localparam logic [7:0] MASK_PULLDOWN_B = 8'h03;
	// ---------------------------------------------
	// field positions
	// ---------------------------------------------
	localparam int BIT_CONV_ENABLE  = 7;
	localparam int BIT_DEC_RESET    = 0;
	localparam int RATIO_LSB        = 1;
	localparam int RATIO_W          = 4;
	localparam logic [3:0] RATIO_MAX_CODE = 4'ha;
	localparam logic [3:0] RATIO_MIN_CODE = 4'h1;
	// ratio 32768 = 2^15, code 1010 gives 2^6
	localparam int RATIO_LOG_TOP    = 15;
	localparam int RATIO_LOG_W      = 4;
	localparam logic [3:0] RATIO_LOG_TOP_V = 4'hf;
	localparam int RESULT_W         = 24;
	localparam int ACC_W            = 2 * RATIO_LOG_TOP + 2;
	localparam int BIT_SENSOR_EN    = 1;
	localparam int BIT_SENSOR_SWAP  = 0;

	// ---------------------------------------------
	// analog control word driven to the converter
	// ---------------------------------------------
	typedef struct packed {
		logic       converter_enable;
		logic       reference_scale;
		logic [2:0] input_gain_select;
		logic [2:0] bias_level_select;
		logic [3:0] input_offset_select;
		logic [3:0] positive_input_select;
		logic [3:0] negative_input_select;
		logic [1:0] reference_high_select;
		logic [1:0] reference_low_select;
		logic [1:0] input_swap_select;
		logic       reference_short;
		logic       input_short;
		logic       common_mode_enable;
		logic       low_source_buffer_enable;
		logic       common_mode_level_select;
		logic       regulator_pulldown_switch;
		logic       channel_bias_enable;
		logic       temp_sensor_enable;
		logic       sensor_polarity_swap;
		logic [1:0] pin3_pulldown_select;
		logic [1:0] pin5_pulldown_select;
	} sdadc_analog_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sdadc_bus_req_t;
endpackage

// >>> hw/sdadc_comb.sv
// second-order comb decimator fed by the one-bit modulator stream
`timescale 1ns/10ps
module sdadc_comb #(
	parameter int ACC_W = 32
) (
	// clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             rst_i,
	// control
	input  wire logic             clear_i,
	input  wire logic             run_i,
	input  wire logic             sample_en_i,
	input  wire logic             bit_i,
	input  wire logic             dump_i,
	// result
	output logic [ACC_W-1:0]      diff_o,
	output logic                  valid_o
);
	initial
	begin
		if (ACC_W < 4)
			$error("comb accumulator too narrow");
	end

	typedef struct packed {
		logic [ACC_W-1:0] int1;
		logic [ACC_W-1:0] int2;
		logic [ACC_W-1:0] last;
		logic [ACC_W-1:0] prev_diff;
		logic [ACC_W-1:0] diff;
		logic             valid;
	} sdadc_comb_st_t;

	sdadc_comb_st_t st;
	sdadc_comb_st_t next_st;
	logic [ACC_W-1:0] in_val;
	logic [ACC_W-1:0] d1;

	// ---------------------------------------------
	// integrators at sample rate, combs at output rate
	// ---------------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.valid = 1'b0;
		in_val = bit_i ? ACC_W'(1) : ACC_W'(-1);
		d1 = st.int2 - st.last;
		if (clear_i || !run_i)
			next_st = '0;
		else if (sample_en_i)
		begin
			next_st.int1 = st.int1 + in_val;
			next_st.int2 = st.int2 + st.int1;
			if (dump_i)
			begin
				next_st.last = st.int2;
				next_st.prev_diff = d1;
				next_st.diff = d1 - st.prev_diff;
				next_st.valid = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			st <= '0;
		else
			st <= next_st;
	end

	assign diff_o  = st.diff;
	assign valid_o = st.valid;
endmodule

// >>> hw/sdadc_ctrl.sv
// sigma-delta converter control and result registers with decimation sequencing
//
// Overview of operation
// RQ1 - sensor needs both converter enable and sensor enable set by software.
// RQ2 - first sensor reading: both selectors 0010, polarity swap clear.
// RQ3 - second sensor reading: both selectors 0011, polarity swap set.
// RQ4 - software averages the two chopped readings to cancel sensor offset.
// RQ5 - ratio field bits 4..1: 0000/0001 32768, halving to 64 at 1010, above 32768.
// RQ6 - writing one to bit 0 resets modulator and decimator at the write.
// RQ7 - gain register bit 5 selects reference scaling unity or half.
// RQ8 - gain field codes 000..110 give x1/4..x16; 111 reserved.
// RQ9 - bias field bits 6..4 select 0.20 to 0.55 of supply.
// RQ10 - offset field, bit 3 sign, paired magnitudes of reference difference.
// RQ11 - positive input selector codes route sensors, pins, supply, bias, ground.
// RQ12 - negative input selector codes route ground, sensors, pins, 1.2 V, bias.
// RQ13 - two-bit high and low reference selectors pick their sources.
// RQ14 - two-bit swap field routes or swaps inputs to modulator high and low.
// RQ15 - routing register bit 0 shorts inputs, bit 1 shorts references.
// RQ16 - switch register bit 7 common-mode on, bit 6 1.2 V buffer on.
// RQ17 - switch register bit 5 common-mode level: half supply or 1.2 V.
// RQ18 - software sets bit 4 pull-down when using regulator or half-supply reference.
// RQ19 - switch register bit 3 connects bias to the input channel.
// RQ20 - switch register bit 0 reverses sensor polarity, bit 1 powers sensor.
// RQ21 - result in three byte registers; high byte holds only six bits.
// RQ22 - pull-down registers: bits 7..6 pin 3, bits 1..0 other pin.
// RQ23 - result is 24-bit two's complement with two low bits zero.
// RQ24 - one new result per decimation period of the sampling clock.
// RQ25 - all three result bytes update together from one conversion.
// RQ26 - reset bit reads zero after reset; conversion restarts fresh period.
`timescale 1ns/10ps
module sdadc_ctrl #(
	parameter int SAMPLE_DIV = 40
) (
	// clock and reset
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_i,
	// register port
	input  wire logic [7:0]            reg_addr_i,
	input  wire logic [7:0]            reg_wdata_i,
	input  wire logic                  reg_wr_i,
	input  wire logic                  reg_rd_i,
	output logic [7:0]                 reg_rdata_o,
	// modulator
	input  wire logic                  mod_bit_i,
	output logic                       mod_reset_o,
	output logic                       sample_en_o,
	// analog settings
	output sdadc_pkg::sdadc_analog_t   analog_o
);
	initial
	begin
		if (SAMPLE_DIV < 2 || SAMPLE_DIV > 255)
			$error("sample divider out of range");
	end

	typedef struct packed {
		logic [7:0]  r_enable;
		logic [7:0]  r_gain;
		logic [7:0]  r_bias;
		logic [7:0]  r_input;
		logic [7:0]  r_ref;
		logic [7:0]  r_switch;
		logic [7:0]  r_pd_a;
		logic [7:0]  r_pd_b;
		logic [23:0] result;
		logic [7:0]  rdata;
		logic [7:0]  div_cnt;
		logic        sample_en;
		logic [14:0] period_cnt;
		logic        dump;
		logic        clear;
		logic        sensor_on;
	} sdadc_st_t;

	sdadc_st_t st;
	sdadc_st_t next_st;

	logic [sdadc_pkg::ACC_W-1:0] comb_diff;
	logic                        comb_valid;
	logic [3:0]                  ratio_code;
	logic [3:0]                  ratio_log;
	logic [14:0]                 period_last;
	logic [sdadc_pkg::ACC_W-1:0] scaled;
	logic                        run;

	// ---------------------------------------------
	// decimation ratio decode
	// ---------------------------------------------
	assign ratio_code = st.r_enable[sdadc_pkg::RATIO_LSB +: sdadc_pkg::RATIO_W];
	always_comb
	begin
		// codes 0000/0001 and above 1010 fall back to 32768 [RQ5]
		if (ratio_code <= sdadc_pkg::RATIO_MIN_CODE || ratio_code > sdadc_pkg::RATIO_MAX_CODE)
			ratio_log = sdadc_pkg::RATIO_LOG_TOP_V;
		else
			ratio_log = sdadc_pkg::RATIO_LOG_TOP_V - (ratio_code - sdadc_pkg::RATIO_MIN_CODE);
	end
	assign period_last = 15'((32'd1 << ratio_log) - 32'd1); // [RQ5]
	assign run = st.r_enable[sdadc_pkg::BIT_CONV_ENABLE];

	sdadc_comb #(
		.ACC_W       (sdadc_pkg::ACC_W)
	) u_comb (
		.core_clk_i  (core_clk_i),
		.rst_i       (rst_i),
		.clear_i     (st.clear),
		.run_i       (run),
		.sample_en_i (st.sample_en),
		.bit_i       (mod_bit_i),
		.dump_i      (st.dump),
		.diff_o      (comb_diff),
		.valid_o     (comb_valid)
	);

	// full scale of a second-order comb is 2*ratio^2; align to 24 bits
	assign scaled = $signed(comb_diff) <<< (2 * (sdadc_pkg::RATIO_LOG_TOP - 32'(ratio_log)));

	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.clear = 1'b0;
		next_st.sample_en = 1'b0;
		next_st.dump = 1'b0;
		next_st.rdata = sdadc_pkg::RST_ZERO;
		// sample rate enable
		if (st.div_cnt == 8'(SAMPLE_DIV - 1))
		begin
			next_st.div_cnt = 8'h00;
			next_st.sample_en = run;
		end
		else
			next_st.div_cnt = st.div_cnt + 8'h01;
		// period counter, one dump per ratio samples [RQ24]
		if (st.clear || !run)
			next_st.period_cnt = 15'h0000;
		else if (st.sample_en)
		begin
			if (st.period_cnt >= period_last)
				next_st.period_cnt = 15'h0000;
			else
				next_st.period_cnt = st.period_cnt + 15'h0001;
		end
		if (!st.clear && run && st.div_cnt == 8'(SAMPLE_DIV - 1) && st.period_cnt >= period_last)
			next_st.dump = 1'b1;
		// whole 24-bit word in one cycle, low two bits zero [RQ25] [RQ23]
		if (comb_valid && !st.clear)
			next_st.result = {scaled[sdadc_pkg::ACC_W-1 -: 22], 2'b00};
		// register writes
		if (reg_wr_i)
		begin
			unique case (reg_addr_i)
				sdadc_pkg::ADDR_CTRL_ENABLE:
				begin
					// reset bit is a write action, never stored [RQ6] [RQ26]
					next_st.r_enable = reg_wdata_i & sdadc_pkg::MASK_ENABLE;
					next_st.clear = reg_wdata_i[sdadc_pkg::BIT_DEC_RESET];
				end
				sdadc_pkg::ADDR_CTRL_GAIN:   next_st.r_gain = reg_wdata_i & sdadc_pkg::MASK_GAIN;
				sdadc_pkg::ADDR_CTRL_BIAS:   next_st.r_bias = reg_wdata_i & sdadc_pkg::MASK_BIAS;
				sdadc_pkg::ADDR_CTRL_INPUT:  next_st.r_input = reg_wdata_i;
				sdadc_pkg::ADDR_CTRL_REF:    next_st.r_ref = reg_wdata_i;
				sdadc_pkg::ADDR_CTRL_SWITCH: next_st.r_switch = reg_wdata_i & sdadc_pkg::MASK_SWITCH;
				sdadc_pkg::ADDR_PULLDOWN_A:  next_st.r_pd_a = reg_wdata_i & sdadc_pkg::MASK_PULLDOWN_A;
				sdadc_pkg::ADDR_PULLDOWN_B:  next_st.r_pd_b = reg_wdata_i & sdadc_pkg::MASK_PULLDOWN_B;
				default:
				begin
				end
			endcase
		end
		// a fresh period after a reset write [RQ26]
		if (next_st.clear)
		begin
			next_st.period_cnt = 15'h0000;
			next_st.dump = 1'b0;
		end
		// sensor power is sensor enable gated by converter enable, kept in a flop [RQ1] [RQ20]
		next_st.sensor_on = next_st.r_switch[sdadc_pkg::BIT_SENSOR_EN]
			& next_st.r_enable[sdadc_pkg::BIT_CONV_ENABLE];
		// register reads, data in the next cycle
		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				sdadc_pkg::ADDR_RESULT_HIGH:   next_st.rdata = st.result[23:16] & sdadc_pkg::MASK_HIGH; // [RQ21]
				sdadc_pkg::ADDR_RESULT_MIDDLE: next_st.rdata = st.result[15:8];
				sdadc_pkg::ADDR_RESULT_LOW:    next_st.rdata = st.result[7:0];
				sdadc_pkg::ADDR_CTRL_ENABLE:   next_st.rdata = st.r_enable;
				sdadc_pkg::ADDR_CTRL_GAIN:     next_st.rdata = st.r_gain;
				sdadc_pkg::ADDR_CTRL_BIAS:     next_st.rdata = st.r_bias;
				sdadc_pkg::ADDR_CTRL_INPUT:    next_st.rdata = st.r_input;
				sdadc_pkg::ADDR_CTRL_REF:      next_st.rdata = st.r_ref;
				sdadc_pkg::ADDR_CTRL_SWITCH:   next_st.rdata = st.r_switch;
				sdadc_pkg::ADDR_PULLDOWN_A:    next_st.rdata = st.r_pd_a;
				sdadc_pkg::ADDR_PULLDOWN_B:    next_st.rdata = st.r_pd_b;
				default:                       next_st.rdata = sdadc_pkg::RST_ZERO;
			endcase
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			st <= '0;
			st.r_ref <= sdadc_pkg::RST_CTRL_REF;
		end
		else
			st <= next_st;
	end

	// ---------------------------------------------
	// outputs, all from flip-flops
	// ---------------------------------------------
	assign reg_rdata_o = st.rdata;
	assign mod_reset_o = st.clear;      // [RQ6]
	assign sample_en_o = st.sample_en;
	always_comb
	begin
		analog_o.converter_enable          = st.r_enable[sdadc_pkg::BIT_CONV_ENABLE];
		analog_o.reference_scale           = st.r_gain[5];      // [RQ7]
		analog_o.input_gain_select         = st.r_gain[2:0];    // [RQ8]
		analog_o.bias_level_select         = st.r_bias[6:4];    // [RQ9]
		analog_o.input_offset_select       = st.r_bias[3:0];    // [RQ10]
		analog_o.positive_input_select     = st.r_input[7:4];   // [RQ11]
		analog_o.negative_input_select     = st.r_input[3:0];   // [RQ12]
		analog_o.reference_high_select     = st.r_ref[7:6];     // [RQ13]
		analog_o.reference_low_select      = st.r_ref[5:4];     // [RQ13]
		analog_o.input_swap_select         = st.r_ref[3:2];     // [RQ14]
		analog_o.reference_short           = st.r_ref[1];       // [RQ15]
		analog_o.input_short               = st.r_ref[0];       // [RQ15]
		analog_o.common_mode_enable        = st.r_switch[7];    // [RQ16]
		analog_o.low_source_buffer_enable  = st.r_switch[6];    // [RQ16]
		analog_o.common_mode_level_select  = st.r_switch[5];    // [RQ17]
		analog_o.regulator_pulldown_switch = st.r_switch[4];
		analog_o.channel_bias_enable       = st.r_switch[3];    // [RQ19]
		analog_o.temp_sensor_enable        = st.sensor_on;      // [RQ1]
		analog_o.sensor_polarity_swap      = st.r_switch[sdadc_pkg::BIT_SENSOR_SWAP]; // [RQ20]
		analog_o.pin3_pulldown_select      = st.r_pd_a[7:6];    // [RQ22]
		analog_o.pin5_pulldown_select      = st.r_pd_b[1:0];    // [RQ22]
	end

	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	reset_pulse_a: assert property (reg_wr_i && reg_addr_i == sdadc_pkg::ADDR_CTRL_ENABLE
		&& reg_wdata_i[0] |=> mod_reset_o ##1 (!mod_reset_o
		|| $past(reg_wr_i && reg_addr_i == sdadc_pkg::ADDR_CTRL_ENABLE && reg_wdata_i[0]))) // [RQ6]
		else $error("reset write did not pulse modulator reset");
	reset_reads_zero_a: assert property (reg_rd_i && reg_addr_i == sdadc_pkg::ADDR_CTRL_ENABLE
		|=> reg_rdata_o[0] == 1'b0) // [RQ26]
		else $error("reset bit read back as one");
	high_six_bits_a: assert property (reg_rd_i && reg_addr_i == sdadc_pkg::ADDR_RESULT_HIGH
		|=> reg_rdata_o[7:6] == 2'b00) // [RQ21]
		else $error("result high byte upper bits set");
	low_bits_zero_a: assert property (st.result[1:0] == 2'b00) // [RQ23]
		else $error("result low bits not zero");
	result_atomic_a: assert property ($changed(st.result) |-> $past(comb_valid)) // [RQ25]
		else $error("result changed without decimator output");
	ratio_default_a: assert property ((ratio_code == 4'h0 || ratio_code > 4'ha)
		|-> period_last == 15'h7fff) // [RQ5]
		else $error("ratio code fallback wrong");
	ratio_min_a: assert property (ratio_code == 4'ha |-> period_last == 15'h003f) // [RQ5]
		else $error("ratio 64 period wrong");
	sensor_gate_a: assert property (analog_o.temp_sensor_enable |-> analog_o.converter_enable) // [RQ1]
		else $error("sensor on without converter");
	dump_period_a: assert property (st.dump |=> !st.dump [*2]) // [RQ24]
		else $error("decimator dumped twice in a row");
	gain_write_a: assert property (reg_wr_i && reg_addr_i == sdadc_pkg::ADDR_CTRL_GAIN
		|=> analog_o.input_gain_select == $past(reg_wdata_i[2:0])
		&& analog_o.reference_scale == $past(reg_wdata_i[5])) // [RQ8]
		else $error("gain write not applied");
	switch_write_a: assert property (reg_wr_i && reg_addr_i == sdadc_pkg::ADDR_CTRL_SWITCH
		|=> analog_o.common_mode_enable == $past(reg_wdata_i[7])
		&& analog_o.sensor_polarity_swap == $past(reg_wdata_i[0])) // [RQ16]
		else $error("switch write not applied");

	cover_reset_write_c: cover property (mod_reset_o);
	cover_result_c:      cover property (comb_valid);
	cover_sensor_c:      cover property (analog_o.temp_sensor_enable && analog_o.sensor_polarity_swap);
endmodule

// >>> tb/sdadc_ctrl_bench.sv
// self-checking bench for the converter control and result registers
`timescale 1ns/10ps
module sdadc_ctrl_bench;
	// ---------------------------------------------
	// signals
	// ---------------------------------------------
	localparam int DIV = 2;
	logic                     core_clk;
	logic                     rst;
	logic [7:0]               reg_addr;
	logic [7:0]               reg_wdata;
	logic                     reg_wr;
	logic                     reg_rd;
	logic [7:0]               reg_rdata;
	logic                     mod_bit;
	logic                     mod_reset;
	logic                     sample_en;
	sdadc_pkg::sdadc_analog_t analog;
	logic [7:0]               sh [256];
	logic [7:0]               ctl [8];
	logic [7:0]               odd [6];
	int                       miscompares;
	int                       checked;

	sdadc_ctrl #(.SAMPLE_DIV(DIV)) u_dut (
		.core_clk_i  (core_clk),
		.rst_i       (rst),
		.reg_addr_i  (reg_addr),
		.reg_wdata_i (reg_wdata),
		.reg_wr_i    (reg_wr),
		.reg_rd_i    (reg_rd),
		.reg_rdata_o (reg_rdata),
		.mod_bit_i   (mod_bit),
		.mod_reset_o (mod_reset),
		.sample_en_o (sample_en),
		.analog_o    (analog)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	always @(posedge core_clk) mod_bit <= 1'($urandom);

	// ---------------------------------------------
	// expectations
	// ---------------------------------------------
	function automatic logic [7:0] mask_of(input logic [7:0] a);
		case (a)
			sdadc_pkg::ADDR_CTRL_ENABLE: return sdadc_pkg::MASK_ENABLE;
			sdadc_pkg::ADDR_CTRL_GAIN:   return sdadc_pkg::MASK_GAIN;
			sdadc_pkg::ADDR_CTRL_BIAS:   return sdadc_pkg::MASK_BIAS;
			sdadc_pkg::ADDR_CTRL_INPUT:  return 8'hff;
			sdadc_pkg::ADDR_CTRL_REF:    return 8'hff;
			sdadc_pkg::ADDR_CTRL_SWITCH: return sdadc_pkg::MASK_SWITCH;
			sdadc_pkg::ADDR_PULLDOWN_A:  return sdadc_pkg::MASK_PULLDOWN_A;
			sdadc_pkg::ADDR_PULLDOWN_B:  return sdadc_pkg::MASK_PULLDOWN_B;
			default:                     return 8'h00;
		endcase
	endfunction

	function automatic sdadc_pkg::sdadc_analog_t exp_analog();
		logic [7:0] e, g, b, n, r, s;
		e = sh[sdadc_pkg::ADDR_CTRL_ENABLE];
		g = sh[sdadc_pkg::ADDR_CTRL_GAIN];
		b = sh[sdadc_pkg::ADDR_CTRL_BIAS];
		n = sh[sdadc_pkg::ADDR_CTRL_INPUT];
		r = sh[sdadc_pkg::ADDR_CTRL_REF];
		s = sh[sdadc_pkg::ADDR_CTRL_SWITCH];
		return {e[7], g[5], g[2:0], b[6:4], b[3:0], n[7:4], n[3:0], r[7:6], r[5:4], r[3:2],
			r[1], r[0], s[7], s[6], s[5], s[4], s[3], s[1] & e[7], s[0],
			sh[sdadc_pkg::ADDR_PULLDOWN_A][7:6], sh[sdadc_pkg::ADDR_PULLDOWN_B][1:0]};
	endfunction

	// ---------------------------------------------
	// bus cycles and comparison
	// ---------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		sh[a] = d & mask_of(a);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask

	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		close_out();
	end

	// ---------------------------------------------
	// tests
	// ---------------------------------------------
	initial
	begin
		logic [7:0] a, d, q, prev;
		int         n, c, t, t1, per;
		void'($urandom(32'h2370));
		ctl = '{8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h47, 8'h48};
		odd = '{8'h00, 8'h39, 8'h43, 8'h46, 8'h49, 8'hff};
		foreach (sh[i]) sh[i] = 8'h00;
		sh[sdadc_pkg::ADDR_CTRL_REF] = sdadc_pkg::RST_CTRL_REF;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		miscompares = 0;
		checked = 0;
		rst = 1'b1;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 8'h3a; i <= 8'h42; i++)
		begin
			rd(8'(i), q);
			check(q, sh[i]);
		end
		rd(sdadc_pkg::ADDR_CTRL_REF, q);
		@(negedge core_clk);
		check(reg_rdata, 8'h00);
		check(analog, exp_analog());
		$display("test reset values done");
		for (int i = 0; i < 48; i++)
		begin
			a = ctl[i % 8];
			d = (i < 16) ? ((i < 8) ? 8'h00 : 8'hff) : 8'($urandom);
			if (a == sdadc_pkg::ADDR_CTRL_GAIN && d[2:0] == 3'h7)
				d[2:0] = 3'h6;
			wr(a, d);
			rd(a, q);
			check(q, sh[a]);
			check(analog, exp_analog());
		end
		$display("test register fields done");
		wr(sdadc_pkg::ADDR_CTRL_SWITCH, 8'h00);
		@(negedge core_clk);
		check(analog, exp_analog());
		wr(sdadc_pkg::ADDR_CTRL_ENABLE, 8'h80);
		wr(sdadc_pkg::ADDR_CTRL_INPUT, 8'h22);
		wr(sdadc_pkg::ADDR_CTRL_SWITCH, 8'h12);
		@(negedge core_clk);
		check(analog, exp_analog());
		wr(sdadc_pkg::ADDR_CTRL_INPUT, 8'h33);
		wr(sdadc_pkg::ADDR_CTRL_SWITCH, 8'h03);
		@(negedge core_clk);
		check(analog, exp_analog());
		$display("test sensor setup done");
		foreach (odd[i])
		begin
			wr(odd[i], 8'($urandom));
			rd(odd[i], q);
			check(q, 8'h00);
			check(analog, exp_analog());
		end
		$display("test unmapped done");
		wr(sdadc_pkg::ADDR_CTRL_ENABLE, 8'h81);
		@(negedge core_clk);
		check(mod_reset, 1'b1);
		@(negedge core_clk);
		check(mod_reset, 1'b0);
		rd(sdadc_pkg::ADDR_CTRL_ENABLE, q);
		check(q, 8'h80);
		wr(sdadc_pkg::ADDR_CTRL_ENABLE, 8'h80);
		@(negedge core_clk);
		check(mod_reset, 1'b0);
		$display("test decimator reset done");
		n = 0;
		while (sample_en !== 1'b1 && n < 100)
		begin
			@(negedge core_clk);
			n++;
		end
		n = 0;
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while (sample_en !== 1'b1 && n < 100);
		check(n, DIV);
		wr(sdadc_pkg::ADDR_CTRL_ENABLE, 8'h00);
		repeat (2) @(negedge core_clk);
		c = 0;
		repeat (20)
		begin
			@(negedge core_clk);
			c += (sample_en !== 1'b0);
		end
		check(c, 0);
		$display("test sampling done");
		for (int k = 0; k < 2; k++)
		begin
			per = (64 << k) * DIV;
			wr(sdadc_pkg::ADDR_CTRL_ENABLE, {1'b1, 2'b00, 4'ha - 4'(k), 1'b1});
			@(posedge core_clk);
			reg_addr <= sdadc_pkg::ADDR_RESULT_MIDDLE;
			reg_rd <= 1'b1;
			repeat (2) @(negedge core_clk);
			prev = reg_rdata;
			{n, c, t, t1} = '0;
			while (c < 3 && n < 5 * per)
			begin
				@(negedge core_clk);
				n++;
				if (reg_rdata !== prev)
					c++;
				if (reg_rdata !== prev && c == 2)
					t1 = n;
				if (reg_rdata !== prev && c == 3)
					t = n - t1;
				prev = reg_rdata;
			end
			@(posedge core_clk);
			reg_rd <= 1'b0;
			check(t, per);
			rd(sdadc_pkg::ADDR_RESULT_HIGH, q);
			check(q & 8'hc0, 8'h00);
			rd(sdadc_pkg::ADDR_RESULT_LOW, q);
			check(q & 8'h03, 8'h00);
		end
		$display("test result period done");
		close_out();
	end
endmodule
